/* File: port_eight_pkg.sv */
/*
  Constants for the eight-bit port that doubles as the upper external data byte.
  Assumes a plain register port with a four-bit address and eight-bit data.
*/
package port_eight_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] direction_offset = 4'h0;
  localparam logic [3:0] output_latch_offset = 4'h1;
  localparam logic [3:0] pin_level_offset = 4'h2;
  localparam logic [3:0] mode_control_offset = 4'h3;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int expansion_mode_pos = 0;
  localparam logic [7:0] direction_reset = 8'h00;
  localparam logic [7:0] output_latch_reset = 8'h00;
  localparam logic expansion_mode_reset = 1'h0;
  localparam logic [7:0] write_only_read_value = 8'h00;
  localparam logic [7:0] unmapped_read_value = 8'h00;

endpackage

/* File: port_eight_gpio.sv */
/*
  Eight-bit general purpose port whose pins can carry external data bus bits 8 to 15.
  Assumes pin inputs synchronous to clk and an external bus controller driving the
  upper data byte while expansion mode is on.
*/
`timescale 1ns/1ps

module port_eight_gpio #(
  parameter int width = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [width-1:0] pin_in,
  output logic [width-1:0] pin_out,
  output logic [width-1:0] pin_oe,
  input wire logic [width-1:0] bus_out,
  input wire logic bus_oe,
  output logic [width-1:0] bus_in,
  output logic expansion_mode
);

  // ****************************************
  // Register state
  // ****************************************
  logic [width-1:0] direction_reg;
  logic [width-1:0] output_latch_reg;
  logic expansion_mode_bit;
  logic [width-1:0] pin_level_reg;
  logic [width-1:0] next_pin_out;
  logic [width-1:0] next_pin_oe;

  // Direction register, write only
  always_ff @(posedge clk) begin
    if (rst) begin
      direction_reg <= port_eight_pkg::direction_reset[width-1:0];
    end else if (wr && addr == port_eight_pkg::direction_offset) begin
      direction_reg <= wdata[width-1:0];
    end
  end

  // Output latch
  always_ff @(posedge clk) begin
    if (rst) begin
      output_latch_reg <= port_eight_pkg::output_latch_reset[width-1:0];
    end else if (wr && addr == port_eight_pkg::output_latch_offset) begin
      output_latch_reg <= wdata[width-1:0];
    end
  end

  // Mode control, expansion bit
  always_ff @(posedge clk) begin
    if (rst) begin
      expansion_mode_bit <= port_eight_pkg::expansion_mode_reset;
    end else if (wr && addr == port_eight_pkg::mode_control_offset) begin
      expansion_mode_bit <= wdata[port_eight_pkg::expansion_mode_pos];
    end
  end

  // ****************************************
  // Pin level view
  // ****************************************
  // Per bit: latch when output, live pin when input; no reset value
  genvar i;
  generate
    for (i = 0; i < width; i++) begin : g_level
      assign pin_level_reg[i] = direction_reg[i] ? output_latch_reg[i] : pin_in[i];
    end
  endgenerate

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        port_eight_pkg::direction_offset: begin
          rdata <= port_eight_pkg::write_only_read_value;
        end
        port_eight_pkg::output_latch_offset: begin
          rdata <= 8'(output_latch_reg);
        end
        port_eight_pkg::pin_level_offset: begin
          rdata <= 8'(pin_level_reg);
        end
        port_eight_pkg::mode_control_offset: begin
          rdata <= 8'(expansion_mode_bit);
        end
        default: begin
          rdata <= port_eight_pkg::unmapped_read_value;
        end
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ****************************************
  // Pin function select
  // ****************************************
  always_comb begin
    if (expansion_mode_bit) begin
      next_pin_out = bus_out;
      next_pin_oe = {width{bus_oe}};
    end else begin
      next_pin_out = output_latch_reg;
      next_pin_oe = direction_reg;
    end
  end

  // Registered pin drive
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end

  // Pin levels towards the bus controller
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_in <= '0;
      expansion_mode <= 1'h0;
    end else begin
      bus_in <= pin_in;
      expansion_mode <= expansion_mode_bit;
    end
  end

endmodule

/* File: port_eight_gpio_asserts.sv */
/* Port checker for port_eight_gpio.
   Sees only the top ports; bound below. */
`timescale 1ns/1ps
module port_eight_gpio_chk (
  input logic clk,
  input logic rst,
  input logic [3:0] addr,
  input logic [7:0] wdata,
  input logic wr,
  input logic rd,
  input logic [7:0] rdata,
  input logic [7:0] pin_in,
  input logic [7:0] pin_out,
  input logic [7:0] pin_oe,
  input logic [7:0] bus_out,
  input logic bus_oe,
  input logic [7:0] bus_in,
  input logic expansion_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  dir_read_a: assert property (rd && addr == 4'h0 |=> rdata == port_eight_pkg::write_only_read_value)
    else $error("direction read not fixed");
  latch_back_a: assert property (wr && addr == 4'h1 ##1 !wr ##1 rd && addr == 4'h1 |=> rdata == $past(wdata, 3))
    else $error("latch readback wrong");
  pin_read_a: assert property (rd && addr == 4'h2 && !expansion_mode && !$past(wr && addr == 4'h0)
    |=> (rdata & ~$past(pin_oe)) == ($past(pin_in) & ~$past(pin_oe)))
    else $error("input pin read wrong");
  latch_read_a: assert property (rd && addr == 4'h2 && !expansion_mode && !$past(wr && (addr == 4'h0 || addr == 4'h1))
    |=> (rdata & $past(pin_oe)) == ($past(pin_out) & $past(pin_oe)))
    else $error("output pin read wrong");
  gpio_dir_a: assert property (wr && addr == 4'h0 ##1 !expansion_mode |=> pin_oe == $past(wdata, 2))
    else $error("direction not on enables");
  mode_bit_a: assert property (wr && addr == 4'h3 |-> ##2 expansion_mode == $past(wdata[0], 2))
    else $error("mode bit not written");
  exp_drive_a: assert property (bus_oe ##1 expansion_mode |-> pin_oe == 8'hff && pin_out == $past(bus_out))
    else $error("bus drive not on pins");
  exp_float_a: assert property (!bus_oe ##1 expansion_mode |-> pin_oe == 8'h00)
    else $error("pins driven without bus");
  bus_in_a: assert property (!$past(rst) |-> bus_in == $past(pin_in))
    else $error("bus input copy wrong");
endmodule
bind port_eight_gpio port_eight_gpio_chk i_port_eight_gpio_chk (.*);

/* File: pin_far_end.sv */
/* Pin model at the port's far side.
   Undriven pins follow the ext level. */
`timescale 1ns/1ps
module pin_far_end (
  input logic [7:0] pin_out,
  input logic [7:0] pin_oe,
  input logic [7:0] ext,
  output logic [7:0] pin_in
);
  // Driven pins read back their drive
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

/* File: port_eight_gpio_data_bus_mux_test.sv */
/* Bench for port_eight_gpio.
   Uses pin_far_end and the bound checker. */
`timescale 1ns/1ps
module port_eight_gpio_data_bus_mux_test;
  logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, bus_oe = 1'h0, expansion_mode;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, bus_out = 8'h00, ext = 8'h3c, rdata, pin_in, pin_out, pin_oe, bus_in;
  int miscompares, n_compared, cyc;
  port_eight_gpio i_port_eight_gpio (.*);
  pin_far_end i_pin_far_end (.*);
  always #5 clk = ~clk;
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %0t got %h want %h", $time, s, e);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
    rd <= 1'h0;
    #1;
    if (!w) chk(rdata, d);
  endtask
  task finish_test;
    $display("miscompares %0d n_compared %0d", miscompares, n_compared);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      miscompares++;
      finish_test;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    bus(1'h0, 4'h0, 8'h00);
    bus(1'h0, 4'h2, 8'h3c);
    bus(1'h1, 4'h1, 8'ha5);
    bus(1'h0, 4'h1, 8'ha5);
    bus(1'h1, 4'h0, 8'h0f);
    bus(1'h0, 4'h2, 8'h35);
    bus(1'h1, 4'h2, 8'hff);
    bus(1'h0, 4'h2, 8'h35);
    chk(pin_oe, 8'h0f);
    bus(1'h1, 4'h3, 8'h01);
    @(posedge clk);
    bus_oe <= 1'h1;
    bus_out <= 8'hc3;
    repeat (3) @(posedge clk);
    #1;
    chk(pin_oe, 8'hff);
    chk(pin_out, 8'hc3);
    chk(bus_in, 8'hc3);
    chk(8'(expansion_mode), 8'h01);
    finish_test;
  end
endmodule
